// *** arsc_pkg.sv ***
// Package for the converter reference and ground selection control block.
// Assumes an 8-bit special function register bus with a 4-bit page and 8-bit address.
package arsc_pkg;

  // Register pages and addresses.
  localparam logic [3:0] PAGE_CFG = 4'h0;
  localparam logic [3:0] PAGE_FACTORY = 4'hF;
  localparam logic [7:0] ADDR_TEMP_OFFSET_LOW = 8'h85;
  localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH = 8'h86;
  localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hD1;

  // Reference control field positions.
  localparam int unsigned BIT_GND_SEL = 5;
  localparam int unsigned BIT_SEL_HI = 4;
  localparam int unsigned BIT_SEL_LO = 3;
  localparam int unsigned BIT_TEMP_EN = 2;
  localparam int unsigned BIT_PREC_OE = 0;
  localparam logic [7:0] REF_CTRL_WMASK = 8'h3D;
  localparam logic [7:0] REF_CTRL_RESET = 8'h18;

  // Offset value layout.
  localparam int unsigned OFFSET_W = 10;
  localparam logic [5:0] OFFSET_LOW_PAD = 6'h00;

  // Reference source encodings.
  typedef enum logic [1:0] {
    ARSC_REF_EXT_PIN = 2'h0,
    ARSC_REF_MAIN_SUPPLY = 2'h1,
    ARSC_REF_DIG_SUPPLY = 2'h2,
    ARSC_REF_HIGH_SPEED = 2'h3
  } arsc_ref_e;

  // Register bus request.
  typedef struct packed {
    logic [3:0] page;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } arsc_bus_s;

  // Analog steering outputs.
  typedef struct packed {
    logic [1:0] ref_route;
    logic hs_ref_power;
    logic prec_ref_enable;
    logic temp_sensor_enable;
    logic use_analog_ground_pin;
  } arsc_analog_s;

endpackage

// *** arsc_offset_store.sv ***
// Holder for the factory temperature offset value.
// Assumes trim_value is a stable fuse output, loaded once at reset release.
`timescale 1ns/1ns
module arsc_offset_store #(
  parameter int unsigned WIDTH = 10
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Fuse side and stored value.
  input wire logic [WIDTH-1:0] trim_value,
  output logic [WIDTH-1:0] stored_value_ff
);

  logic loaded_ff;

  // Captured after reset release, since a reset may only load a constant.
  always_ff @(posedge clk) begin
    if (reset) begin
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= 1'b1;
    end
  end

  // Value differs per part; it is taken from the trim and never written by software.
  always_ff @(posedge clk) begin
    if (reset) begin
      stored_value_ff <= '0;
    end else if (!loaded_ff) begin
      stored_value_ff <= trim_value;
    end
  end

endmodule // arsc_offset_store

// *** arsc_reference_control.sv ***
// Overview of operation
// - Page 0xF address 0x86 reads offset bits 9:2, read only.
// - Page 0xF address 0x85 reads offset bits 1:0 in 7:6, zeros below.
// - Offset content is a per-part production trim, not a fixed constant.
// - Control bit 5 picks analog ground pin when 1, ground pin when 0.
// - Bits 4:3 route reference: external pin, supply, digital supply, high-speed.
// - High-speed reference powered only while converter needs it when selected.
// - Bit 0 enables precision reference and connects it to the reference pin.
// - Bit 2 enables the temperature sensor; clear leaves it high impedance.
// - Sampling the temperature sensor forces chip ground during sampling.
// - High-speed reference selected forces chip ground during conversion.
// - Otherwise enabled analog ground pin serves tracking and conversion.
// - Control bits 7:6 and 1 read zero and ignore writes.
//
// Top of the reference control block; assumes single-cycle register bus strobes
// and converter phase levels synchronous to clk.
`timescale 1ns/1ns
module arsc_reference_control
  import arsc_pkg::*;
#(
  parameter int unsigned OFFSET_WIDTH = OFFSET_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register bus.
  input wire arsc_pkg::arsc_bus_s bus_req,
  output logic [7:0] bus_rdata_ff,
  // Converter status.
  input wire logic conv_active,
  input wire logic track_phase,
  input wire logic conv_phase,
  input wire logic temp_sensor_sampled,
  // Factory trim.
  input wire logic [OFFSET_WIDTH-1:0] trim_value,
  // Analog steering.
  output arsc_pkg::arsc_analog_s analog_ff
);

  logic [7:0] reference_control_ff;
  logic [OFFSET_WIDTH-1:0] temp_offset_value;
  logic sel_cfg;
  logic sel_factory;
  logic [7:0] nxt_rdata;
  arsc_analog_s nxt_analog;
  arsc_ref_e reference_select;

  arsc_offset_store #(
    .WIDTH(OFFSET_WIDTH)
  ) u_offset (
    .clk(clk),
    .reset(reset),
    .trim_value(trim_value),
    .stored_value_ff(temp_offset_value)
  );

  // Page qualifies every access, so same addresses on other pages stay free.
  assign sel_cfg = (bus_req.page == PAGE_CFG);
  assign sel_factory = (bus_req.page == PAGE_FACTORY);
  assign reference_select = arsc_ref_e'(reference_control_ff[BIT_SEL_HI:BIT_SEL_LO]);

  // Control register writes; unused bits are masked so they stay zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      reference_control_ff <= REF_CTRL_RESET;
    end else if (bus_req.wr && sel_cfg && bus_req.addr == ADDR_REFERENCE_CONTROL) begin
      reference_control_ff <= bus_req.wdata & REF_CTRL_WMASK;
    end
  end

  // Read decode; offset registers have no write path at all.
  always_comb begin
    nxt_rdata = 8'h00;
    if (sel_factory && bus_req.addr == ADDR_TEMP_OFFSET_HIGH) begin
      nxt_rdata = temp_offset_value[OFFSET_WIDTH-1:OFFSET_WIDTH-8];
    end else if (sel_factory && bus_req.addr == ADDR_TEMP_OFFSET_LOW) begin
      nxt_rdata = {temp_offset_value[1:0], OFFSET_LOW_PAD};
    end else if (sel_cfg && bus_req.addr == ADDR_REFERENCE_CONTROL) begin
      nxt_rdata = reference_control_ff & REF_CTRL_WMASK;
    end
  end

  // Read data is registered; it is valid the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_rdata_ff <= 8'h00;
    end else if (bus_req.rd) begin
      bus_rdata_ff <= nxt_rdata;
    end
  end

  // Analog steering; ground overrides win over the ground select bit.
  always_comb begin
    nxt_analog.ref_route = reference_select;
    nxt_analog.hs_ref_power = (reference_select == ARSC_REF_HIGH_SPEED) && conv_active;
    nxt_analog.prec_ref_enable = reference_control_ff[BIT_PREC_OE];
    nxt_analog.temp_sensor_enable = reference_control_ff[BIT_TEMP_EN];
    nxt_analog.use_analog_ground_pin = reference_control_ff[BIT_GND_SEL];
    if (track_phase && temp_sensor_sampled) begin
      nxt_analog.use_analog_ground_pin = 1'b0;
    end else if (conv_phase && reference_select == ARSC_REF_HIGH_SPEED) begin
      nxt_analog.use_analog_ground_pin = 1'b0;
    end else if (track_phase || conv_phase) begin
      nxt_analog.use_analog_ground_pin = reference_control_ff[BIT_GND_SEL];
    end
  end

  // Outputs are registered, so they lag the phase inputs by one cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      analog_ff <= '0;
    end else begin
      analog_ff <= nxt_analog;
    end
  end

  // Assertions.
  property p_ctrl_unused_zero;
    @(posedge clk) disable iff (reset)
    (reference_control_ff & ~REF_CTRL_WMASK) == 8'h00;
  endproperty
  a_ctrl_unused_zero: assert property (p_ctrl_unused_zero) else $error("Unused control bits set.");

  property p_read_high;
    @(posedge clk) disable iff (reset)
    bus_req.rd && sel_factory && bus_req.addr == ADDR_TEMP_OFFSET_HIGH
      |=> bus_rdata_ff == $past(temp_offset_value[OFFSET_WIDTH-1:OFFSET_WIDTH-8]);
  endproperty
  a_read_high: assert property (p_read_high) else $error("Offset high read wrong.");

  property p_read_low;
    @(posedge clk) disable iff (reset)
    bus_req.rd && sel_factory && bus_req.addr == ADDR_TEMP_OFFSET_LOW
      |=> bus_rdata_ff == {$past(temp_offset_value[1:0]), OFFSET_LOW_PAD};
  endproperty
  a_read_low: assert property (p_read_low) else $error("Offset low read wrong.");

  property p_wrong_page;
    @(posedge clk) disable iff (reset)
    bus_req.rd && !sel_cfg && !sel_factory |=> bus_rdata_ff == 8'h00;
  endproperty
  a_wrong_page: assert property (p_wrong_page) else $error("Other page answered.");

  // Starts only out of reset, since the steering register resets to zero while the control register does not.
  property p_route;
    @(posedge clk) disable iff (reset)
    !reset |=> analog_ff.ref_route == $past(reference_control_ff[BIT_SEL_HI:BIT_SEL_LO]);
  endproperty
  a_route: assert property (p_route) else $error("Reference route wrong.");

  property p_hs_power;
    @(posedge clk) disable iff (reset)
    reference_select != ARSC_REF_HIGH_SPEED || !conv_active |=> !analog_ff.hs_ref_power;
  endproperty
  a_hs_power: assert property (p_hs_power) else $error("High-speed reference powered idle.");

  property p_prec;
    @(posedge clk) disable iff (reset)
    1'b1 |=> analog_ff.prec_ref_enable == $past(reference_control_ff[BIT_PREC_OE]);
  endproperty
  a_prec: assert property (p_prec) else $error("Precision enable wrong.");

  property p_temp_en;
    @(posedge clk) disable iff (reset)
    1'b1 |=> analog_ff.temp_sensor_enable == $past(reference_control_ff[BIT_TEMP_EN]);
  endproperty
  a_temp_en: assert property (p_temp_en) else $error("Sensor enable wrong.");

  property p_temp_ground;
    @(posedge clk) disable iff (reset)
    track_phase && temp_sensor_sampled |=> !analog_ff.use_analog_ground_pin;
  endproperty
  a_temp_ground: assert property (p_temp_ground) else $error("Sensor sampling not on chip ground.");

  property p_hs_ground;
    @(posedge clk) disable iff (reset)
    conv_phase && reference_select == ARSC_REF_HIGH_SPEED |=> !analog_ff.use_analog_ground_pin;
  endproperty
  a_hs_ground: assert property (p_hs_ground) else $error("Conversion not on chip ground.");

  property p_agnd;
    @(posedge clk) disable iff (reset)
    reference_control_ff[BIT_GND_SEL] && !(track_phase && temp_sensor_sampled)
      && !(conv_phase && reference_select == ARSC_REF_HIGH_SPEED) |=> analog_ff.use_analog_ground_pin;
  endproperty
  a_agnd: assert property (p_agnd) else $error("Analog ground pin not used.");

  c_hs_conv: cover property (@(posedge clk) disable iff (reset) analog_ff.hs_ref_power);
  c_temp_sample: cover property (@(posedge clk) disable iff (reset) track_phase && temp_sensor_sampled);
  c_ctrl_write: cover property (@(posedge clk) disable iff (reset)
    bus_req.wr && sel_cfg && bus_req.addr == ADDR_REFERENCE_CONTROL);

endmodule // arsc_reference_control

// *** adc_reference_select_control_test.sv ***
// Self-checking bench for the reference and ground selection control block.
// Assumes the package and the top design module are compiled first.
`timescale 1ns/1ns
module adc_reference_select_control_test;
  import arsc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  arsc_bus_s bus_req = '0;
  logic [7:0] bus_rdata_ff;
  logic conv_active = 1'b0;
  logic track_phase = 1'b0;
  logic conv_phase = 1'b0;
  logic temp_sensor_sampled = 1'b0;
  logic [9:0] trim_value = 10'h2A5;
  arsc_analog_s analog_ff;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic armed = 1'b0;
  logic [15:0] lf = 16'h563E;
  logic [15:0] lg;
  logic [7:0] m_reg = 8'h18;
  logic [7:0] m_rd = 8'h00;
  arsc_analog_s m_an = '0;

  arsc_reference_control u_dut (.clk(clk), .reset(reset), .bus_req(bus_req), .bus_rdata_ff(bus_rdata_ff),
    .conv_active(conv_active), .track_phase(track_phase), .conv_phase(conv_phase),
    .temp_sensor_sampled(temp_sensor_sampled), .trim_value(trim_value), .analog_ff(analog_ff));

  // Free-running 125 MHz clock.
  initial begin
    forever #4 clk = ~clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Read model; anything not decoded on its own page answers zero.
  function automatic logic [7:0] rd_model(input logic [3:0] pg, input logic [7:0] ad);
    if (pg == 4'hF && ad == 8'h86) return trim_value[9:2];
    if (pg == 4'hF && ad == 8'h85) return {trim_value[1:0], 6'h00};
    if (pg == 4'h0 && ad == 8'hD1) return m_reg;
    return 8'h00;
  endfunction

  // Cycle model of the control register and the registered analog steering.
  always @(posedge clk) begin
    if (reset) begin
      m_reg <= 8'h18;
      m_rd <= 8'h00;
      m_an <= '0;
    end else begin
      m_an.ref_route <= m_reg[4:3];
      m_an.hs_ref_power <= (m_reg[4:3] == 2'h3) && conv_active;
      m_an.prec_ref_enable <= m_reg[0];
      m_an.temp_sensor_enable <= m_reg[2];
      m_an.use_analog_ground_pin <= (temp_sensor_sampled && track_phase) ? 1'b0 :
        ((m_reg[4:3] == 2'h3) && conv_phase) ? 1'b0 : m_reg[5];
      if (bus_req.wr && bus_req.page == 4'h0 && bus_req.addr == 8'hD1) begin
        m_reg <= bus_req.wdata & 8'h3D;
      end
      if (bus_req.rd) begin
        m_rd <= rd_model(bus_req.page, bus_req.addr);
      end
    end
  end

  task automatic cmp_analog(input arsc_analog_s got, input arsc_analog_s exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: analog got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rdata(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: read data got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare on the falling edge, where every registered output has settled.
  always @(negedge clk) begin
    cycles++;
    if (armed) begin
      cmp_analog(analog_ff, m_an);
      cmp_rdata(bus_rdata_ff, m_rd);
    end
    armed = 1'b1;
    if (cycles > 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic drive(input logic [3:0] pg, input logic [7:0] ad, input logic w, input logic r, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{page: pg, addr: ad, wr: w, rd: r, wdata: d};
  endtask

  // Directed accesses then random back-to-back traffic with random converter phases.
  task automatic run_phase();
    logic [7:0] ad;
    logic [3:0] pg;
    drive(4'h0, 8'hD1, 1'b0, 1'b1, 8'h00);
    drive(4'h0, 8'hD1, 1'b1, 1'b0, 8'hFF);
    drive(4'h0, 8'hD1, 1'b0, 1'b1, 8'h00);
    drive(4'hF, 8'hD1, 1'b1, 1'b0, 8'h00);
    drive(4'h0, 8'hD1, 1'b1, 1'b0, 8'h01);
    drive(4'h0, 8'hD1, 1'b0, 1'b1, 8'h00);
    drive(4'h0, 8'hD1, 1'b1, 1'b0, 8'h00);
    drive(4'h3, 8'hD1, 1'b0, 1'b1, 8'h00);
    drive(4'hF, 8'h85, 1'b1, 1'b0, 8'hFF);
    drive(4'hF, 8'h85, 1'b0, 1'b1, 8'h00);
    drive(4'hF, 8'h86, 1'b0, 1'b1, 8'h00);
    drive(4'h0, 8'h86, 1'b0, 1'b1, 8'h00);
    drive(4'h0, 8'hD1, 1'b0, 1'b1, 8'h00);
    for (int i = 0; i < 1500; i++) begin
      lf = lfsr_next(lf);
      lg = lfsr_next(lfsr_next(lf));
      ad = (lf[2:1] == 2'h0) ? 8'h85 : (lf[2:1] == 2'h1) ? 8'h86 : (lf[2:1] == 2'h2) ? 8'hD1 : lg[15:8];
      pg = lf[0] ? 4'hF : (lf[6] & lf[7]) ? lg[7:4] : 4'h0;
      drive(pg, ad, lf[3] & lf[4], ~(lf[3] & lf[4]) & lf[5], lf[15:8] ^ lg[7:0]);
      conv_active <= lg[0];
      track_phase <= lg[1];
      conv_phase <= lg[2];
      temp_sensor_sampled <= lg[3];
    end
    @(posedge clk);
    bus_req <= '0;
    repeat (3) @(posedge clk);
  endtask

  // Main sequence: reset, traffic, a second reset with a new trim, traffic again.
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    run_phase();
    reset <= 1'b1;
    trim_value <= 10'h15A;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    run_phase();
    tally_and_finish();
  end
endmodule // adc_reference_select_control_test
